//--- rtl/apc_regs_top.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// - Full-chip sleep set powers down core, references and all drivers.
// - Driver sleep set powers down data and clock pins, tristated.
// - Swing code applies only when its enable field is 11; 01/10 unused.
// - The pedestal is a signed 6-bit value added after correction.
// - The 12-bit variant takes its pedestal from bits 7 to 4 only.
// - With correction on, the output converges to mid-code plus the pedestal.
// - Hold freezes the estimate and keeps applying the last value.
// - The span code sets 2**(20+code) cycles, 1M up to 2G at 1011.
// - Low-speed mode is on only for field value 11, off at reset.
// - The swing code sits in bits 7 to 2 of its own register.
// - The dc removal enable bit switches the correction loop.
module apc_regs_top #(
    parameter bit WIDE_VARIANT = 1'b1
) (
    input  wire logic                        clock,          // 200 MHz
    input  wire logic                        rst,            // sync reset
    input  wire logic [7:0]                  reg_addr,       // reg address
    input  wire logic [7:0]                  reg_wdata,      // write data
    input  wire logic                        reg_wr,         // write strobe
    input  wire logic                        reg_rd,         // read strobe
    output logic [7:0]                       reg_rdata,      // read data
    input  wire logic [apc_pkg::DATA_W-1:0]  adc_sample,     // core sample
    output logic [apc_pkg::DATA_W-1:0]       out_data,       // data pins
    output logic                             out_data_oe,    // data drive
    output logic                             out_clk_oe,     // clock drive
    output logic                             core_sleep,     // core off
    output logic                             ref_sleep,      // refs off
    output logic                             output_driver_sleep, // drv off
    output logic [5:0]                       swing_code,     // swing used
    output logic                             high_freq_perf_mode, // hf mode
    output logic                             low_speed_mode  // low speed
);
    import apc_pkg::*;

    // ************************************************************
    // register storage
    // ************************************************************
    logic              full_chip_sleep_reg;
    logic              output_driver_sleep_reg;
    logic [1:0]        swing_en_reg;
    logic [5:0]        swing_field_reg;
    logic              dc_removal_enable_reg;
    logic              high_freq_perf_mode_reg;
    logic [5:0]        ped_field_reg;
    logic              hold_dc_estimate_reg;
    logic [3:0]        dc_loop_averaging_span_reg;
    logic [1:0]        rate_field_reg;
    logic [7:0]        rdata_reg;

    // ************************************************************
    // output flops
    // ************************************************************
    logic [DATA_W-1:0] out_data_reg;
    logic              out_data_oe_reg;
    logic              out_clk_oe_reg;
    logic              core_sleep_reg;
    logic              ref_sleep_reg;
    logic              drv_sleep_out_reg;
    logic [5:0]        swing_code_reg;
    logic              hf_out_reg;
    logic              low_speed_reg;

    // ************************************************************
    // address decode
    // ************************************************************
    wire        wr_swing  = reg_wr && (reg_addr == ADDR_SWING);
    wire        wr_format = reg_wr && (reg_addr == ADDR_FORMAT);
    wire        wr_power  = reg_wr && (reg_addr == ADDR_POWER);
    wire        wr_hf     = reg_wr && (reg_addr == ADDR_HF);
    wire        wr_ped    = reg_wr && (reg_addr == ADDR_PED);
    wire        wr_loop   = reg_wr && (reg_addr == ADDR_LOOP);
    wire        wr_rate   = reg_wr && (reg_addr == ADDR_RATE);

    // ************************************************************
    // register writes
    // ************************************************************
    // reserved bits are simply not stored, so they always read zero
    always_ff @(posedge clock) begin
        if (rst) begin
            full_chip_sleep_reg     <= RST_BIT;
            output_driver_sleep_reg <= RST_BIT;
            swing_en_reg            <= RST_SWING_EN;
        end else if (wr_power) begin
            full_chip_sleep_reg     <= reg_wdata[BIT_FULL_SLEEP];
            output_driver_sleep_reg <= reg_wdata[BIT_DRV_SLEEP];
            swing_en_reg            <= reg_wdata[SWING_EN_LSB +: 2];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            swing_field_reg <= RST_SWING_CODE;
        end else if (wr_swing) begin
            swing_field_reg <= reg_wdata[SWING_CODE_LSB +: 6];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            dc_removal_enable_reg   <= RST_BIT;
            high_freq_perf_mode_reg <= RST_BIT;
        end else begin
            if (wr_format) begin
                dc_removal_enable_reg <= reg_wdata[BIT_DC_EN];
            end
            if (wr_hf) begin
                high_freq_perf_mode_reg <= reg_wdata[BIT_HF];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ped_field_reg              <= RST_PED;
            hold_dc_estimate_reg       <= RST_BIT;
            dc_loop_averaging_span_reg <= RST_SPAN;
            rate_field_reg             <= RST_LOW_SPEED;
        end else begin
            if (wr_ped) begin
                ped_field_reg <= reg_wdata[PED_LSB +: 6];
            end
            if (wr_loop) begin
                hold_dc_estimate_reg       <= reg_wdata[BIT_HOLD];
                dc_loop_averaging_span_reg <= reg_wdata[SPAN_LSB +: 4];
            end
            if (wr_rate) begin
                rate_field_reg <= reg_wdata[LOW_SPEED_LSB +: 2];
            end
        end
    end

    // ************************************************************
    // offset loop
    // ************************************************************
    logic signed [EST_W-1:0]   centered;
    logic signed [EST_W-1:0]   estimate;
    logic [3:0]                span_clamped;
    logic [SHIFT_W-1:0]        shift;
    logic signed [7:0]         ped_val;
    logic signed [SUM_W-1:0]   sum;
    logic [DATA_W-1:0]         sat;
    logic [DATA_W-1:0]         out_mask;
    logic [DATA_W-1:0]         data_next;
    logic                      awake;

    assign centered     = $signed({1'b0, adc_sample}) - $signed({1'b0, MID_CODE});
    assign span_clamped = (dc_loop_averaging_span_reg > TC_MAX_CODE)
                        ? TC_MAX_CODE
                        : dc_loop_averaging_span_reg;
    assign shift        = TC_BASE_LOG2 + {1'b0, span_clamped};

    apc_dc_estimator u_est (
        .clock    (clock),
        .rst      (rst),
        .enable   (dc_removal_enable_reg),
        .hold     (hold_dc_estimate_reg),
        .shift    (shift),
        .centered (centered),
        .estimate (estimate)
    );

    // the narrow variant weighs its 4-bit pedestal in 12-bit steps
    assign ped_val  = WIDE_VARIANT
                    ? {{2{ped_field_reg[5]}}, ped_field_reg}
                    : {{2{ped_field_reg[5]}}, ped_field_reg[5:2],
                       2'b00};
    assign sum      = $signed({3'b000, adc_sample})
                    - $signed({{2{estimate[EST_W-1]}}, estimate})
                    + $signed({{9{ped_val[7]}}, ped_val});
    // clipping instead of wrapping keeps a large pedestal monotonic
    assign sat      = sum[SUM_W-1] ? '0
                    : (sum > $signed(SAMPLE_MAX)) ? FULL_MASK
                    : sum[DATA_W-1:0];
    assign out_mask = WIDE_VARIANT ? FULL_MASK : LOW12_MASK;
    assign data_next = (dc_removal_enable_reg ? sat : adc_sample)
                     & out_mask;
    assign awake    = !full_chip_sleep_reg && !output_driver_sleep_reg;

    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            out_data_reg    <= '0;
            out_data_oe_reg <= 1'b0;
            out_clk_oe_reg  <= 1'b0;
        end else begin
            out_data_reg    <= awake ? data_next : '0;
            out_data_oe_reg <= awake;
            out_clk_oe_reg  <= awake;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            core_sleep_reg    <= RST_BIT;
            ref_sleep_reg     <= RST_BIT;
            drv_sleep_out_reg <= RST_BIT;
            swing_code_reg    <= RST_SWING_CODE;
            hf_out_reg        <= RST_BIT;
            low_speed_reg     <= RST_BIT;
        end else begin
            core_sleep_reg    <= full_chip_sleep_reg;
            ref_sleep_reg     <= full_chip_sleep_reg;
            drv_sleep_out_reg <= output_driver_sleep_reg
                              || full_chip_sleep_reg;
            swing_code_reg    <= (swing_en_reg == SWING_ON)
                              ? swing_field_reg
                              : RST_SWING_CODE;
            hf_out_reg        <= high_freq_perf_mode_reg;
            low_speed_reg     <= (rate_field_reg == LOW_SPEED_ON);
        end
    end

    assign out_data            = out_data_reg;
    assign out_data_oe         = out_data_oe_reg;
    assign out_clk_oe          = out_clk_oe_reg;
    assign core_sleep          = core_sleep_reg;
    assign ref_sleep           = ref_sleep_reg;
    assign output_driver_sleep = drv_sleep_out_reg;
    assign swing_code          = swing_code_reg;
    assign high_freq_perf_mode = hf_out_reg;
    assign low_speed_mode      = low_speed_reg;

    // ************************************************************
    // read back
    // ************************************************************
    logic [7:0] rd_value;
    logic [7:0] est_hi;

    assign est_hi   = {{(16 - EST_W){estimate[EST_W-1]}}, estimate[14:8]};
    assign rd_value =
        (reg_addr == ADDR_SWING)  ? {swing_field_reg, 2'b00}
      : (reg_addr == ADDR_FORMAT) ? {2'b00, dc_removal_enable_reg, 5'h00}
      : (reg_addr == ADDR_POWER)  ? {1'b0, full_chip_sleep_reg, 1'b0,
                                     output_driver_sleep_reg, 2'b00,
                                     swing_en_reg}
      : (reg_addr == ADDR_HF)     ? {7'h00, high_freq_perf_mode_reg}
      : (reg_addr == ADDR_PED)    ? {ped_field_reg, 2'b00}
      : (reg_addr == ADDR_LOOP)   ? {hold_dc_estimate_reg, 1'b0,
                                     dc_loop_averaging_span_reg, 2'b00}
      : (reg_addr == ADDR_RATE)   ? {2'b00, rate_field_reg, 4'h0}
      : (reg_addr == ADDR_EST_LO) ? estimate[7:0]
      : (reg_addr == ADDR_EST_HI) ? est_hi
      : RST_RDATA;

    // data stands for exactly the cycle after the strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_reg <= RST_RDATA;
        end else begin
            rdata_reg <= reg_rd ? rd_value : RST_RDATA;
        end
    end

    assign reg_rdata = rdata_reg;

    // ************************************************************
    // checks
    // ************************************************************
    property p_full_sleep;
        @(posedge clock) disable iff (rst)
        full_chip_sleep_reg |=> core_sleep && ref_sleep && !out_data_oe
                                && !out_clk_oe && out_data == '0;
    endproperty
    a_full_sleep: assert property (p_full_sleep)
        else $error("full sleep did not power down");

    property p_driver_sleep;
        @(posedge clock) disable iff (rst)
        output_driver_sleep_reg |=> !out_data_oe && !out_clk_oe
                                    && output_driver_sleep;
    endproperty
    a_driver_sleep: assert property (p_driver_sleep)
        else $error("drivers still enabled in driver sleep");

    property p_swing_apply;
        @(posedge clock) disable iff (rst)
        swing_en_reg == SWING_ON |=> swing_code == $past(swing_field_reg);
    endproperty
    a_swing_apply: assert property (p_swing_apply)
        else $error("enabled swing code not applied");

    property p_swing_ignore;
        @(posedge clock) disable iff (rst)
        swing_en_reg != SWING_ON |=> swing_code == RST_SWING_CODE;
    endproperty
    a_swing_ignore: assert property (p_swing_ignore)
        else $error("swing code applied while disabled");

    property p_pedestal_top;
        @(posedge clock) disable iff (rst)
        ped_field_reg == 6'h1F |-> ped_val == (WIDE_VARIANT ? 8'sh1F
                                                            : 8'sh1C);
    endproperty
    a_pedestal_top: assert property (p_pedestal_top)
        else $error("pedestal weight wrong for variant");

    property p_pedestal_min;
        @(posedge clock) disable iff (rst)
        ped_field_reg == 6'h20 |-> ped_val == 8'shE0;
    endproperty
    a_pedestal_min: assert property (p_pedestal_min)
        else $error("pedestal not read as signed");

    property p_span_long;
        @(posedge clock) disable iff (rst)
        dc_loop_averaging_span_reg >= TC_MAX_CODE |-> shift == 5'h1F;
    endproperty
    a_span_long: assert property (p_span_long)
        else $error("long span codes not clamped");

    property p_span_base;
        @(posedge clock) disable iff (rst)
        dc_loop_averaging_span_reg == 4'h0 |-> shift == 5'h14;
    endproperty
    a_span_base: assert property (p_span_base)
        else $error("shortest span is not 1M cycles");

    property p_bypass;
        @(posedge clock) disable iff (rst)
        !dc_removal_enable_reg && awake
        |=> out_data == ($past(adc_sample) & out_mask);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("sample altered with correction off");

    property p_low_speed;
        @(posedge clock) disable iff (rst)
        rate_field_reg != LOW_SPEED_ON |=> !low_speed_mode;
    endproperty
    a_low_speed: assert property (p_low_speed)
        else $error("low speed on for a non-enabling value");

    sequence s_loop_write;
        reg_wr && reg_addr == ADDR_LOOP;
    endsequence
    sequence s_loop_read;
        reg_rd && reg_addr == ADDR_LOOP;
    endsequence
    property p_loop_readback;
        @(posedge clock) disable iff (rst)
        s_loop_write ##1 s_loop_read
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'hBC);
    endproperty
    a_loop_readback: assert property (p_loop_readback)
        else $error("loop register read back wrong");

endmodule

//--- rtl/apc_pkg.sv
package apc_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned DATA_W  = 14;
    localparam int unsigned EST_W   = 15;
    localparam int unsigned ACC_W   = 47;
    localparam int unsigned SHIFT_W = 5;
    localparam int unsigned SUM_W   = 17;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_SWING  = 8'h01;
    localparam logic [7:0] ADDR_FORMAT = 8'h3D;
    localparam logic [7:0] ADDR_POWER  = 8'h43;
    localparam logic [7:0] ADDR_HF     = 8'h4A;
    localparam logic [7:0] ADDR_PED    = 8'hBF;
    localparam logic [7:0] ADDR_LOOP   = 8'hCF;
    localparam logic [7:0] ADDR_RATE   = 8'hDF;
    localparam logic [7:0] ADDR_EST_LO = 8'hE0;
    localparam logic [7:0] ADDR_EST_HI = 8'hE1;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned BIT_FULL_SLEEP = 6;
    localparam int unsigned BIT_DRV_SLEEP  = 4;
    localparam int unsigned SWING_EN_LSB   = 0;
    localparam int unsigned SWING_CODE_LSB = 2;
    localparam int unsigned BIT_DC_EN      = 5;
    localparam int unsigned BIT_HF         = 0;
    localparam int unsigned PED_LSB        = 2;
    localparam int unsigned BIT_HOLD       = 7;
    localparam int unsigned SPAN_LSB       = 2;
    localparam int unsigned LOW_SPEED_LSB  = 4;

    // ************************************************************
    // values after reset
    // ************************************************************
    localparam logic [5:0] RST_SWING_CODE = 6'h00;
    localparam logic [1:0] RST_SWING_EN   = 2'h0;
    localparam logic [5:0] RST_PED        = 6'h00;
    localparam logic [3:0] RST_SPAN       = 4'h0;
    localparam logic [1:0] RST_LOW_SPEED  = 2'h0;
    localparam logic       RST_BIT        = 1'b0;
    localparam logic [7:0] RST_RDATA      = 8'h00;

    // ************************************************************
    // codes and loop constants
    // ************************************************************
    localparam logic [1:0]        SWING_ON     = 2'h3;
    localparam logic [1:0]        LOW_SPEED_ON = 2'h3;
    localparam logic [DATA_W-1:0] MID_CODE     = 14'h2000;
    localparam logic [DATA_W-1:0] FULL_MASK    = 14'h3FFF;
    localparam logic [DATA_W-1:0] LOW12_MASK   = 14'h3FFC;
    localparam logic [SUM_W-1:0]  SAMPLE_MAX   = 17'h03FFF;
    // 1M cycles is two to the twentieth
    localparam logic [SHIFT_W-1:0] TC_BASE_LOG2 = 5'h14;
    localparam logic [3:0]         TC_MAX_CODE  = 4'hB;

endpackage

//--- rtl/apc_dc_estimator.sv
`timescale 1ns/1ps
module apc_dc_estimator (
    input  wire logic                             clock,    // sample clock
    input  wire logic                             rst,      // sync reset
    input  wire logic                             enable,   // loop active
    input  wire logic                             hold,     // freeze
    input  wire logic [apc_pkg::SHIFT_W-1:0]      shift,    // log2 span
    input  wire logic signed [apc_pkg::EST_W-1:0] centered, // x - mid
    output logic signed [apc_pkg::EST_W-1:0]      estimate  // dc estimate
);
    import apc_pkg::*;

    logic signed [ACC_W-1:0]  acc_reg;
    logic signed [ACC_W-1:0]  acc_next;
    logic signed [ACC_W-1:0]  shifted;
    logic [SHIFT_W-1:0]       shift_reg;
    logic signed [EST_W:0]    err;

    // ************************************************************
    // first-order loop
    // ************************************************************
    // acc settles at estimate << shift, so the span is 2**shift cycles
    assign shifted  = acc_reg >>> shift_reg;
    assign estimate = shifted[EST_W-1:0];
    assign err      = {centered[EST_W-1], centered}
                    - {estimate[EST_W-1], estimate};
    // frozen loop keeps its last estimate applied every cycle
    assign acc_next = !enable ? '0
                    : hold    ? acc_reg
                    : acc_reg + ACC_W'(err);

    always_ff @(posedge clock) begin
        if (rst) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // span only follows the register while not frozen, so a span
    // rewrite during a freeze cannot move the applied estimate
    always_ff @(posedge clock) begin
        if (rst) begin
            shift_reg <= TC_BASE_LOG2;
        end else if (!hold) begin
            shift_reg <= shift;
        end
    end

    property p_hold_stable;
        @(posedge clock) disable iff (rst)
        enable && hold |=> $stable(acc_reg) && $stable(estimate);
    endproperty
    a_hold_stable: assert property (p_hold_stable)
        else $error("estimate moved while frozen");

    property p_off_clears;
        @(posedge clock) disable iff (rst)
        !enable |=> acc_reg == '0;
    endproperty
    a_off_clears: assert property (p_off_clears)
        else $error("loop state kept while disabled");

endmodule

//--- test/tb_adc_power_offset_config_regs.sv
`timescale 1ns/1ps
module tb_adc_power_offset_config_regs;
    import apc_pkg::*;
    // ************************************************************
    // signals
    // ************************************************************
    logic              clock = 1'b0;
    logic              rst = 1'b1;
    logic [7:0]        reg_addr = 8'h00;
    logic [7:0]        reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [7:0]        reg_rdata;
    logic [DATA_W-1:0] adc_sample = 14'h0000;
    logic [DATA_W-1:0] out_data;
    logic              out_data_oe, out_clk_oe, core_sleep, ref_sleep;
    logic              output_driver_sleep, high_freq_perf_mode;
    logic              low_speed_mode;
    logic [5:0]        swing_code;
    logic [7:0]        addrs[7] = '{ADDR_HF, ADDR_PED, ADDR_LOOP, ADDR_RATE,
                                    ADDR_POWER, ADDR_FORMAT, ADDR_SWING};
    logic [7:0]        peds[4] = '{8'h7C, 8'h80, 8'hFC, 8'h00};
    logic [7:0]        d;
    int                error_cnt = 0;
    int                compares = 0;

    always #2.5 clock = ~clock;

    apc_regs_top uut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .adc_sample(adc_sample), .out_data(out_data),
        .out_data_oe(out_data_oe), .out_clk_oe(out_clk_oe),
        .core_sleep(core_sleep), .ref_sleep(ref_sleep),
        .output_driver_sleep(output_driver_sleep), .swing_code(swing_code),
        .high_freq_perf_mode(high_freq_perf_mode),
        .low_speed_mode(low_speed_mode));

    // ************************************************************
    // expectations and bus tasks
    // ************************************************************
    // reserved bits are never stored, so they read back as zero
    function automatic logic [7:0] reg_mask(input logic [7:0] a);
        case (a)
            ADDR_HF:     return 8'h01;
            ADDR_PED:    return 8'hFC;
            ADDR_LOOP:   return 8'hBC;
            ADDR_RATE:   return 8'h30;
            ADDR_POWER:  return 8'h53;
            ADDR_FORMAT: return 8'h20;
            ADDR_SWING:  return 8'hFC;
            default:     return 8'h00;
        endcase
    endfunction

    // frozen zero estimate: output is sample plus signed pedestal, clamped
    function automatic logic [13:0] exp_out(input logic [13:0] x,
                                            input logic [5:0] p);
        int v;
        v = int'(x) + int'($signed(p));
        if (v < 0) v = 0;
        if (v > 16383) v = 16383;
        return v[13:0];
    endfunction

    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask

    // write then read back with no gap between the two strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] v,
                         input logic [7:0] exp);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
    endtask

    // sample held over two edges so the registered result has landed
    task automatic smp(input logic [13:0] x, input logic [13:0] exp);
        @(posedge clock);
        adc_sample <= x;
        repeat (2) @(posedge clock);
        #1;
        chk("out_data", out_data, exp);
    endtask

    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (100000) @(posedge clock);
        error_cnt++;
        wrap_up();
    end

    initial begin
        d = 8'($urandom(32'h8cda));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("out_data_oe", out_data_oe, 1);
        chk("core_sleep", core_sleep, 0);
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        rd(8'h77, 8'h00);
        foreach (addrs[i]) begin
            // software keeps reserved bits zero and never writes 01 or 10 to the swing enable
            d = 8'($urandom) & reg_mask(addrs[i]);
            if (addrs[i] == ADDR_POWER && d[1] != d[0]) begin
                d[1:0] = 2'b11;
            end
            wr_rd(addrs[i], d, d);
        end
        wr(ADDR_SWING, 8'hF8);
        for (int e = 0; e < 4; e++) begin
            wr(ADDR_POWER, (e == 3) ? 8'h03 : 8'h00);
            chk("swing_code", swing_code, (e == 3) ? 16'h3E : 16'h0);
            wr(ADDR_RATE, 8'(e << 4));
            chk("low_speed_mode", low_speed_mode, (e == 3));
            wr(ADDR_HF, 8'(e & 1));
            chk("high_freq_perf_mode", high_freq_perf_mode, e & 1);
        end
        wr(ADDR_POWER, 8'h10);
        chk("drv_sleep", output_driver_sleep, 1);
        chk("oe", {out_data_oe, out_clk_oe, core_sleep}, 0);
        wr(ADDR_POWER, 8'h40);
        chk("full_sleep", {core_sleep, ref_sleep, output_driver_sleep}, 7);
        chk("asleep", {out_data_oe, out_clk_oe, out_data}, 0);
        wr(ADDR_POWER, 8'h00);
        chk("awake", {out_data_oe, out_clk_oe, core_sleep}, 6);
        wr(ADDR_FORMAT, 8'h00);
        wr(ADDR_PED, 8'h7C);
        repeat (10) begin
            d = 8'($urandom);
            smp({d[5:0], d}, {d[5:0], d});
        end
        // park the input at mid-code so the loop has nothing to learn
        smp(MID_CODE, MID_CODE);
        wr(ADDR_FORMAT, 8'h20);
        wr(ADDR_LOOP, 8'h80);
        foreach (peds[i]) begin
            wr(ADDR_PED, peds[i]);
            smp(14'h0000, exp_out(14'h0000, peds[i][7:2]));
            smp(14'h3FFF, exp_out(14'h3FFF, peds[i][7:2]));
            smp(MID_CODE + 14'h01F4, exp_out(MID_CODE + 14'h01F4,
                peds[i][7:2]));
            d = 8'($urandom);
            smp({d, d[5:0]}, exp_out({d, d[5:0]}, peds[i][7:2]));
        end
        rd(ADDR_EST_LO, 8'h00);
        rd(ADDR_EST_HI, 8'h00);
        wrap_up();
    end
endmodule
